/* verilog/card_host_config_regs.sv */
/*
 * Card host configuration registers: clock control, timeouts, bus width,
 * block size, byte count and interrupt masks, on an Avalon-MM slave.
 * Assumes the command engine supplies idle, wait levels and pending events.
 */
module card_host_config_regs
   import card_host_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // avalon-mm slave
   input card_host_pkg::avmm_req_t avs_req,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // command engine status
   input wire logic card_idle,
   input wire logic resp_wait,
   input wire logic read_wait,
   input wire logic starve_wait,
   input wire logic [15:0] pending_events,
   // card pin
   input wire logic sdio_irq_n,
   // card side
   output logic cclk_out,
   output card_host_pkg::bus_width_t card_bus_width,
   // transfer setup
   output logic [BLOCK_SIZE_MSB:0] block_length,
   output logic [31:0] byte_total,
   output logic open_ended,
   // detected events
   output logic resp_timeout,
   output logic data_read_timeout,
   output logic starve_timeout,
   output logic sdio_irq_seen,
   output logic irq
);
   import card_host_pkg::*;

   logic [31:0] control;
   logic [31:0] clock_divider;
   logic [31:0] clock_source_select;
   logic [31:0] card_clock_enable;
   logic [31:0] timeout_config;
   logic [31:0] card_bus_width_reg;
   logic [31:0] block_size;
   logic [31:0] transfer_byte_count;
   logic [31:0] interrupt_mask;
   logic [31:0] next_readdata;
   logic write_take;
   logic clk_run;
   logic cclk_tick;
   logic sdio_meta;
   logic sdio_sync;
   logic [MASK_MSB:0] pending;
   int_mask_t mask_fields;

   // writable bits per address; unmapped addresses have none
   function automatic logic [31:0] wmask_of(input logic [31:0] a);
      unique case (a)
         ADDR_CONTROL: wmask_of = WMASK_CONTROL;
         ADDR_CLKDIV: wmask_of = WMASK_CLKDIV;
         ADDR_CLOCK_SOURCE: wmask_of = WMASK_CLOCK_SOURCE;
         ADDR_CLOCK_ENABLE: wmask_of = WMASK_CLOCK_ENABLE;
         ADDR_TIMEOUT: wmask_of = WMASK_TIMEOUT;
         ADDR_BUS_WIDTH: wmask_of = WMASK_BUS_WIDTH;
         ADDR_BLOCK_SIZE: wmask_of = WMASK_BLOCK_SIZE;
         ADDR_BYTE_COUNT: wmask_of = WMASK_BYTE_COUNT;
         ADDR_INT_MASK: wmask_of = WMASK_INT_MASK;
         default: wmask_of = RST_ZERO;
      endcase
   endfunction

   // byte-lane merge that never touches reserved bits
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [31:0] wm);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
      merge = (old & ~m) | (wd & m);
   endfunction

   // bus handshake: one wait cycle, then the answer for one cycle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_req.read || avs_req.write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   assign write_take = avs_req.write && !avs_waitrequest;

   always_comb begin
      unique case (avs_req.address)
         ADDR_CONTROL: next_readdata = control;
         ADDR_CLKDIV: next_readdata = clock_divider;
         ADDR_CLOCK_SOURCE: next_readdata = clock_source_select;
         ADDR_CLOCK_ENABLE: next_readdata = card_clock_enable;
         ADDR_TIMEOUT: next_readdata = timeout_config;
         ADDR_BUS_WIDTH: next_readdata = card_bus_width_reg;
         ADDR_BLOCK_SIZE: next_readdata = block_size;
         ADDR_BYTE_COUNT: next_readdata = transfer_byte_count;
         ADDR_INT_MASK: next_readdata = interrupt_mask;
         default: next_readdata = RST_ZERO;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         avs_readdata <= RST_ZERO;
      end else if (avs_req.read && avs_waitrequest) begin
         avs_readdata <= next_readdata & wmask_of(avs_req.address);
      end
   end

   // register file; a write lands at the edge where waitrequest is low
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         control <= RST_ZERO;
         clock_divider <= RST_ZERO;
         clock_source_select <= RST_ZERO;
         card_clock_enable <= RST_ZERO;
         timeout_config <= RST_TIMEOUT;
         card_bus_width_reg <= RST_ZERO;
         block_size <= RST_BLOCK_SIZE;
         transfer_byte_count <= RST_BYTE_COUNT;
         interrupt_mask <= RST_ZERO;
      end else if (write_take) begin
         unique case (avs_req.address)
            ADDR_CONTROL: control <= merge(control, avs_req.writedata,
                                           avs_req.byteenable, WMASK_CONTROL);
            ADDR_CLKDIV: clock_divider <= merge(clock_divider, avs_req.writedata,
                                                avs_req.byteenable, WMASK_CLKDIV);
            // only source zero exists; the field is kept for readback
            ADDR_CLOCK_SOURCE: clock_source_select <= merge(clock_source_select,
                  avs_req.writedata, avs_req.byteenable, WMASK_CLOCK_SOURCE);
            ADDR_CLOCK_ENABLE: card_clock_enable <= merge(card_clock_enable,
                  avs_req.writedata, avs_req.byteenable, WMASK_CLOCK_ENABLE);
            ADDR_TIMEOUT: timeout_config <= merge(timeout_config, avs_req.writedata,
                  avs_req.byteenable, WMASK_TIMEOUT);
            ADDR_BUS_WIDTH: card_bus_width_reg <= merge(card_bus_width_reg,
                  avs_req.writedata, avs_req.byteenable, WMASK_BUS_WIDTH);
            ADDR_BLOCK_SIZE: block_size <= merge(block_size, avs_req.writedata,
                  avs_req.byteenable, WMASK_BLOCK_SIZE);
            ADDR_BYTE_COUNT: transfer_byte_count <= merge(transfer_byte_count,
                  avs_req.writedata, avs_req.byteenable, WMASK_BYTE_COUNT);
            ADDR_INT_MASK: interrupt_mask <= merge(interrupt_mask, avs_req.writedata,
                  avs_req.byteenable, WMASK_INT_MASK);
            default: ;
         endcase
      end
   end

   // card clock gating, registered so the divider sees a clean level
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         clk_run <= 1'b0;
      end else begin
         clk_run <= card_clock_enable[CLK_ENABLE_BIT]
            && !(card_clock_enable[LOW_POWER_BIT] && card_idle);
      end
   end

   card_clock_gen u_clock_gen (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .run(clk_run),
      .divider(clock_divider[DIV_MSB:0]),
      .cclk_out(cclk_out),
      .tick(cclk_tick)
   );

   // timeouts count card clock cycles, so a stopped clock stops them too
   timeout_timer #(.W(RESP_TMO_MSB + 1)) u_resp_timer (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .run(resp_wait),
      .tick(cclk_tick),
      .limit(timeout_config[RESP_TMO_MSB:0]),
      .expired(resp_timeout)
   );

   timeout_timer #(.W(DATA_TMO_MSB - DATA_TMO_LSB + 1)) u_read_timer (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .run(read_wait),
      .tick(cclk_tick),
      .limit(timeout_config[DATA_TMO_MSB:DATA_TMO_LSB]),
      .expired(data_read_timeout)
   );

   timeout_timer #(.W(DATA_TMO_MSB - DATA_TMO_LSB + 1)) u_starve_timer (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .run(starve_wait),
      .tick(cclk_tick),
      .limit(timeout_config[DATA_TMO_MSB:DATA_TMO_LSB]),
      .expired(starve_timeout)
   );

   // bus width decode
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         card_bus_width <= BUS_1BIT;
      end else if (card_bus_width_reg[WIDE_BUS_BIT]) begin
         card_bus_width <= BUS_8BIT;
      end else if (card_bus_width_reg[FOUR_BIT_BIT]) begin
         card_bus_width <= BUS_4BIT;
      end else begin
         card_bus_width <= BUS_1BIT;
      end
   end

   // transfer setup
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         open_ended <= 1'b0;
      end else begin
         open_ended <= (transfer_byte_count == RST_ZERO);
      end
   end

   assign block_length = block_size[BLOCK_SIZE_MSB:0];
   assign byte_total = transfer_byte_count;

   // sdio interrupt pin: two flops before any logic looks at it
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sdio_meta <= 1'b1;
         sdio_sync <= 1'b1;
      end else begin
         sdio_meta <= sdio_irq_n;
         sdio_sync <= sdio_meta;
      end
   end

   assign mask_fields = interrupt_mask[MASK_MSB:0];

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sdio_irq_seen <= 1'b0;
      end else begin
         sdio_irq_seen <= mask_fields.sdio_irq_mask && !sdio_sync;
      end
   end

   // interrupt output; field order in int_mask_t fixes the bit mapping
   assign pending = {sdio_irq_seen, pending_events} & mask_fields;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= control[GLOBAL_INT_BIT] && (|pending);
      end
   end

   chk_clock_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !card_clock_enable[CLK_ENABLE_BIT] |=> ##1 !cclk_out)
      else $error("card clock running while disabled");

   chk_idle_gating: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (card_clock_enable[LOW_POWER_BIT] && card_idle) |=> ##1 !cclk_out)
      else $error("card clock not stopped in low-power idle");

   chk_wide_bus: assert property (@(posedge ref_clk) disable iff (sys_rst)
      card_bus_width_reg[WIDE_BUS_BIT] |=> card_bus_width == BUS_8BIT)
      else $error("eight-bit bus not selected");

   chk_narrow_bus: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !card_bus_width_reg[WIDE_BUS_BIT] |=> card_bus_width ==
         ($past(card_bus_width_reg[FOUR_BIT_BIT]) ? BUS_4BIT : BUS_1BIT))
      else $error("narrow bus width wrong");

   chk_open_ended: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (transfer_byte_count == RST_ZERO) |=> open_ended)
      else $error("zero byte count not flagged open-ended");

   chk_sdio_disable: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !mask_fields.sdio_irq_mask |=> !sdio_irq_seen)
      else $error("sdio interrupt detected while masked");

   chk_irq_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
      irq |-> $past(control[GLOBAL_INT_BIT]) && $past(|pending))
      else $error("interrupt without enable or unmasked source");

   chk_irq_raise: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (control[GLOBAL_INT_BIT] && (|(pending_events & interrupt_mask[15:0]))) |=> irq)
      else $error("unmasked pending source did not raise interrupt");

   chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (avs_req.read && !avs_waitrequest) |-> (avs_readdata & ~wmask_of(avs_req.address)) == '0)
      else $error("reserved bits read non-zero");

   chk_block_size_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (write_take && avs_req.address == ADDR_BLOCK_SIZE && avs_req.byteenable == 4'hF)
      |=> block_length == $past(avs_req.writedata[BLOCK_SIZE_MSB:0]) && block_size[31:16] == '0)
      else $error("block size write did not land");

endmodule // card_host_config_regs

/* verilog/card_host_pkg.sv */
/*
 * Constants and types shared by the card host configuration register slice.
 * Assumes a 32-bit Avalon-MM slave port that decodes full byte addresses.
 */
package card_host_pkg;
   // register byte addresses
   localparam logic [31:0] ADDR_CONTROL = 32'h1800_0000;
   localparam logic [31:0] ADDR_CLKDIV = 32'h1800_0008;
   localparam logic [31:0] ADDR_CLOCK_SOURCE = 32'h1800_000C;
   localparam logic [31:0] ADDR_CLOCK_ENABLE = 32'h1800_0010;
   localparam logic [31:0] ADDR_TIMEOUT = 32'h1800_0014;
   localparam logic [31:0] ADDR_BUS_WIDTH = 32'h1800_0018;
   localparam logic [31:0] ADDR_BLOCK_SIZE = 32'h1800_001C;
   localparam logic [31:0] ADDR_BYTE_COUNT = 32'h1800_0020;
   localparam logic [31:0] ADDR_INT_MASK = 32'h1800_0024;

   // writable bits of each register; the rest read as zero
   localparam logic [31:0] WMASK_CONTROL = 32'h0000_0010;
   localparam logic [31:0] WMASK_CLKDIV = 32'h0000_00FF;
   localparam logic [31:0] WMASK_CLOCK_SOURCE = 32'h0000_0003;
   localparam logic [31:0] WMASK_CLOCK_ENABLE = 32'h0001_0001;
   localparam logic [31:0] WMASK_TIMEOUT = 32'hFFFF_FFFF;
   localparam logic [31:0] WMASK_BUS_WIDTH = 32'h0001_0001;
   localparam logic [31:0] WMASK_BLOCK_SIZE = 32'h0000_FFFF;
   localparam logic [31:0] WMASK_BYTE_COUNT = 32'hFFFF_FFFF;
   localparam logic [31:0] WMASK_INT_MASK = 32'h0001_FFFF;

   // reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] RST_TIMEOUT = 32'hFFFF_FF40;
   localparam logic [31:0] RST_BLOCK_SIZE = 32'h0000_0200;
   localparam logic [31:0] RST_BYTE_COUNT = 32'h0000_0200;

   // field positions
   localparam int GLOBAL_INT_BIT = 4;
   localparam int CLK_ENABLE_BIT = 0;
   localparam int LOW_POWER_BIT = 16;
   localparam int WIDE_BUS_BIT = 16;
   localparam int FOUR_BIT_BIT = 0;
   localparam int SDIO_MASK_BIT = 16;
   localparam int DIV_MSB = 7;
   localparam int RESP_TMO_MSB = 7;
   localparam int DATA_TMO_LSB = 8;
   localparam int DATA_TMO_MSB = 31;
   localparam int BLOCK_SIZE_MSB = 15;
   localparam int MASK_MSB = 16;

   typedef enum logic [1:0] {
      BUS_1BIT = 2'h0,
      BUS_4BIT = 2'h1,
      BUS_8BIT = 2'h2
   } bus_width_t;

   // avalon-mm request from the master
   typedef struct packed {
      logic read;
      logic write;
      logic [31:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } avmm_req_t;

   // interrupt mask register fields, msb first
   typedef struct packed {
      logic sdio_irq_mask;
      logic end_bit_error_mask;
      logic auto_command_done_mask;
      logic start_bit_error_mask;
      logic locked_write_error_mask;
      logic fifo_run_error_mask;
      logic starvation_timeout_mask;
      logic data_read_timeout_mask;
      logic response_timeout_mask;
      logic data_crc_error_mask;
      logic response_crc_error_mask;
      logic receive_fifo_request_mask;
      logic [4:0] low_source_mask;
   } int_mask_t;
endpackage

/* verilog/card_clock_gen.sv */
/*
 * Card output clock generator: divides ref_clk by twice the divider value, a zero divider counting as one.
 * Assumes run comes from a flop on the same clock.
 */
module card_clock_gen
   import card_host_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // control
   input wire logic run,
   input wire logic [DIV_MSB:0] divider,
   // card clock
   output logic cclk_out,
   output logic tick
);
   logic [DIV_MSB:0] count;
   logic [DIV_MSB:0] half;

   // zero is treated as one; the fastest a flop can toggle is half of ref_clk
   assign half = (divider == '0) ? {{DIV_MSB{1'b0}}, 1'b1} : divider;

   always_ff @(posedge ref_clk) begin
      if (sys_rst || !run) begin
         // parked low at once; the last high phase may be short
         count <= '0;
         cclk_out <= 1'b0;
         tick <= 1'b0;
      end else if (count + 1'b1 >= half) begin
         count <= '0;
         cclk_out <= !cclk_out;
         tick <= !cclk_out;
      end else begin
         count <= count + 1'b1;
         tick <= 1'b0;
      end
   end

   chk_half_period: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (run && $past(run) && $changed(cclk_out) && $stable(divider) && divider > 8'h01)
         |=> $stable(cclk_out) [*1])
      else $error("card clock half period too short");

endmodule // card_clock_gen

/* verilog/timeout_timer.sv */
/*
 * Timeout counter that counts card clock ticks while run is high.
 * Assumes tick is a one-cycle pulse per card clock rising edge.
 */
module timeout_timer #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // control
   input wire logic run,
   input wire logic tick,
   input wire logic [W-1:0] limit,
   // result
   output logic expired
);
   logic [W:0] count;
   logic done;

   always_ff @(posedge ref_clk) begin
      if (sys_rst || !run) begin
         count <= '0;
         done <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (tick && !done) begin
            if (count + 1'b1 >= {1'b0, limit}) begin
               expired <= 1'b1;
               done <= 1'b1;
            end else begin
               count <= count + 1'b1;
            end
         end
      end
   end

   chk_expiry_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(expired) |-> ($past(count) + 1'b1 >= {1'b0, $past(limit)}) && $past(tick))
      else $error("timeout fired before its count");

endmodule // timeout_timer

/* bench/card_model.sv */
/*
 * Behavioural model of the card and command engine that face the config slice.
 * Assumes the bench calls its tasks, each of which changes one status group
 * right after a rising edge of ref_clk.
 */
module card_model (
   // clock
   input wire logic ref_clk,
   // status toward the host
   output logic card_idle,
   output logic resp_wait,
   output logic read_wait,
   output logic starve_wait,
   output logic [15:0] pending_events,
   // interrupt pin, pulled up on the board so idle is high
   output logic sdio_irq_n
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      card_idle = 1'b0;
      resp_wait = 1'b0;
      read_wait = 1'b0;
      starve_wait = 1'b0;
      pending_events = 16'h0000;
      sdio_irq_n = 1'b1;
   end

   // the card interrupts on its own sdio_irq_n pin, so gating the clock while idle is safe
   task automatic set_idle(input logic v);
      @(posedge ref_clk);
      card_idle <= v;
   endtask

   // silent card: a wait level stays up until the bench drops it
   task automatic set_wait(input int w);
      @(posedge ref_clk);
      resp_wait <= (w == 0);
      read_wait <= (w == 1);
      starve_wait <= (w == 2);
   endtask

   task automatic set_events(input logic [15:0] e);
      @(posedge ref_clk);
      pending_events <= e;
   endtask

   task automatic set_pin(input logic v);
      @(posedge ref_clk);
      sdio_irq_n <= v;
   endtask
endmodule // card_model

/* bench/tb.sv */
/*
 * Self-checking bench for the card host configuration register slice.
 * Assumes the slice answers each Avalon request after waitrequest falls.
 */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import card_host_pkg::*;

   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   avmm_req_t avs_req = '0;
   logic [31:0] avs_readdata, byte_total, rd;
   logic avs_waitrequest, card_idle, resp_wait, read_wait, starve_wait;
   logic sdio_irq_n, cclk_out, open_ended, resp_timeout, data_read_timeout;
   logic starve_timeout, sdio_irq_seen, irq;
   logic [15:0] pending_events, block_length;
   bus_width_t card_bus_width;
   int n_mismatch = 0;
   int n_checks = 0;
   int cnt;
   logic [31:0] addr_tab [9] = '{ADDR_CLOCK_SOURCE, ADDR_CLOCK_ENABLE, ADDR_TIMEOUT,
      ADDR_BUS_WIDTH, ADDR_BLOCK_SIZE, ADDR_BYTE_COUNT, ADDR_INT_MASK,
      ADDR_CONTROL, ADDR_CLKDIV};
   logic [31:0] rst_tab [9] = '{RST_ZERO, RST_ZERO, RST_TIMEOUT, RST_ZERO,
      RST_BLOCK_SIZE, RST_BYTE_COUNT, RST_ZERO, RST_ZERO, RST_ZERO};
   logic [31:0] wm_tab [9] = '{WMASK_CLOCK_SOURCE, WMASK_CLOCK_ENABLE, WMASK_TIMEOUT,
      WMASK_BUS_WIDTH, WMASK_BLOCK_SIZE, WMASK_BYTE_COUNT, WMASK_INT_MASK,
      WMASK_CONTROL, WMASK_CLKDIV};

   always #12.5 ref_clk = ~ref_clk;

   card_host_config_regs i_card_host_config_regs (.ref_clk, .sys_rst, .avs_req,
      .avs_readdata, .avs_waitrequest, .card_idle, .resp_wait, .read_wait,
      .starve_wait, .pending_events, .sdio_irq_n, .cclk_out, .card_bus_width,
      .block_length, .byte_total, .open_ended, .resp_timeout, .data_read_timeout,
      .starve_timeout, .sdio_irq_seen, .irq);

   card_model i_card_model (.ref_clk, .card_idle, .resp_wait, .read_wait,
      .starve_wait, .pending_events, .sdio_irq_n);

   task automatic end_sim();
      $display("counts: checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int i;
      @(posedge ref_clk);
      avs_req <= '{read: !w, write: w, address: a, writedata: d, byteenable: be};
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 20);
      if (i >= 20) check(avs_waitrequest, 1'b0);
      rd = avs_readdata;
      avs_req <= '0;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   // partial write: only the enabled byte lanes may change
   task automatic wr_be(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
      bus(1'b1, a, d, be);
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, 4'hF);
      check(rd, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic count_high(input int span);
      cnt = 0;
      repeat (span) begin
         @(posedge ref_clk);
         if (cclk_out === 1'b1) cnt++;
      end
   endtask

   // length of one high phase of the card clock, in ref_clk cycles
   task automatic measure_high();
      int i;
      i = 0;
      // skip a high phase already under way, it may be cut short
      while (cclk_out === 1'b1 && i < 50) begin
         @(posedge ref_clk);
         i++;
      end
      while (cclk_out !== 1'b1 && i < 100) begin
         @(posedge ref_clk);
         i++;
      end
      cnt = 0;
      while (cclk_out === 1'b1 && cnt < 50) begin
         @(posedge ref_clk);
         cnt++;
      end
   endtask

   function automatic logic pulse(input int w);
      return (w == 0) ? resp_timeout : (w == 1) ? data_read_timeout : starve_timeout;
   endfunction

   // divider 1 gives a tick every two cycles, so lim ticks span about 2*lim
   task automatic run_wait(input int w, input int lim);
      int n;
      i_card_model.set_wait(w);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pulse(w) !== 1'b1 && n < 200);
      check(n >= 2 * lim - 1 && n <= 2 * lim + 6, 1'b1);
      @(posedge ref_clk);
      check(pulse(w), 1'b0);
      i_card_model.set_wait(3);
   endtask

   initial begin
      cyc(12);
      sys_rst <= 1'b0;
      for (int k = 0; k < 9; k++) rdchk(addr_tab[k], rst_tab[k]);
      check(card_bus_width, BUS_1BIT);
      check(block_length, 16'h0200);
      count_high(20);
      check(cnt, 0);
      for (int k = 0; k < 9; k++) begin
         wr(addr_tab[k], (k == 0) ? 32'h0000_0000 : 32'hFFFF_FFFF);
         rdchk(addr_tab[k], (k == 0) ? 32'h0000_0000 : wm_tab[k]);
      end
      wr(32'h1800_0004, 32'hFFFF_FFFF);
      rdchk(32'h1800_0004, 32'h0000_0000);
      cyc(2);
      check(card_bus_width, BUS_8BIT);
      wr(ADDR_BUS_WIDTH, 32'h0000_0001);
      cyc(2);
      check(card_bus_width, BUS_4BIT);
      wr(ADDR_BUS_WIDTH, 32'h0000_0000);
      cyc(2);
      check(card_bus_width, BUS_1BIT);
      wr(ADDR_BLOCK_SIZE, 32'h0000_0040);
      wr(ADDR_BYTE_COUNT, 32'h0000_0080);
      cyc(2);
      check(block_length, 16'h0040);
      check(byte_total, 32'h0000_0080);
      check(open_ended, 1'b0);
      wr_be(ADDR_BYTE_COUNT, 32'hAABB_CCDD, 4'h5);
      rdchk(ADDR_BYTE_COUNT, 32'h00BB_00DD);
      wr(ADDR_BYTE_COUNT, 32'h0000_0000);
      cyc(2);
      check(open_ended, 1'b1);
      wr(ADDR_CLKDIV, 32'h0000_0003);
      wr(ADDR_CLOCK_ENABLE, 32'h0000_0001);
      measure_high();
      check(cnt, 3);
      wr(ADDR_CLKDIV, 32'h0000_0000);
      measure_high();
      check(cnt, 1);
      wr(ADDR_CLKDIV, 32'h0000_0001);
      wr(ADDR_CLOCK_ENABLE, 32'h0001_0001);
      i_card_model.set_idle(1'b1);
      cyc(4);
      count_high(20);
      check(cnt, 0);
      i_card_model.set_idle(1'b0);
      measure_high();
      check(cnt, 1);
      wr(ADDR_CLOCK_ENABLE, 32'h0000_0000);
      cyc(4);
      count_high(20);
      check(cnt, 0);
      wr(ADDR_CLOCK_ENABLE, 32'h0000_0001);
      wr(ADDR_TIMEOUT, 32'h0000_0305);
      run_wait(0, 5);
      run_wait(1, 3);
      run_wait(2, 3);
      for (int b = 5; b < 16; b++) begin
         wr(ADDR_INT_MASK, 32'h1 << b);
         i_card_model.set_events(16'h1 << b);
         cyc(3);
         check(irq, 1'b1);
         i_card_model.set_events(~(16'h1 << b));
         cyc(3);
         check(irq, 1'b0);
      end
      i_card_model.set_events(16'h8000);
      wr(ADDR_CONTROL, 32'h0000_0000);
      cyc(3);
      check(irq, 1'b0);
      wr(ADDR_CONTROL, 32'h0000_0010);
      cyc(3);
      check(irq, 1'b1);
      i_card_model.set_events(16'h0000);
      wr(ADDR_INT_MASK, 32'h0000_0000);
      i_card_model.set_pin(1'b0);
      cyc(5);
      check(sdio_irq_seen, 1'b0);
      check(irq, 1'b0);
      wr(ADDR_INT_MASK, 32'h0001_0000);
      cyc(5);
      check(sdio_irq_seen, 1'b1);
      check(irq, 1'b1);
      i_card_model.set_pin(1'b1);
      end_sim();
   end

   // the whole sequence takes a few hundred cycles
   initial begin
      cyc(20000);
      n_mismatch++;
      end_sim();
   end
endmodule // tb
